// File: hdl/rvm_top.sv
`timescale 1ns/1ns
// Function
// - Reset clears state; first fetch address is 0x000000.
// - Reset is no exception; no vector lookup happens on reset exit.
// - Primary table: vector zero at 0x000004, two units per vector.
// - Alternate table: vector zero at 0x000104, same spacing and order.
// - Vectors 9 to 16 are capture, compare, timer and DMA zero sources.
// - Vectors 17 to 22 are SPI, UART, ADC and DMA one sources.
// - Vectors 24 to 28 and 30 to 32 serve their listed sources.
// - Vectors 33 to 44 serve compares, timers, external two, UART, SPI, CAN, DMA.
// - Vectors 53, 54 and 67 to 70 serve their listed sources.
// - Vectors 73 to 78, 86 and 87 serve their listed sources.
// - Vectors 1 to 5 are traps; 0, 6 and 7 are reserved.
// - Vector 8 is external zero; other unlisted vectors have no source; tables end at 0x100 and 0x200.
// - Alternate select set takes every entry from the alternate table.
// - Each entry holds a 24-bit handler address loaded by the core.
// - Lower vector wins among equal priority sources.
module rvm_top (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [rvm_pkg::NUM_SRC-1:0] src_req,
  input wire logic alt_table_select,
  input wire logic take,
  input wire logic entry_valid,
  input wire logic [rvm_pkg::ADDR_W-1:0] entry_data,
  output logic [rvm_pkg::ADDR_W-1:0] reset_pc,
  output logic fetch_req,
  output logic [rvm_pkg::ADDR_W-1:0] fetch_addr,
  output logic [rvm_pkg::VEC_W-1:0] fetch_vec,
  output logic handler_valid,
  output logic [rvm_pkg::ADDR_W-1:0] handler_addr,
  output logic pending
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    rvm_pkg::rvm_state_e state;
    rvm_pkg::rvm_fetch_s fetch;
    logic hvalid;
    logic [rvm_pkg::ADDR_W-1:0] haddr;
    logic [rvm_pkg::ADDR_W-1:0] pc;
  } rvm_top_s;

  rvm_top_s cur;
  rvm_top_s next_cur;
  logic [rvm_pkg::SRC_W-1:0] win_src;
  logic [rvm_pkg::VEC_W-1:0] win_vec;
  logic win_used;
  logic [rvm_pkg::ADDR_W-1:0] base;
  logic [rvm_pkg::PAD_W-1:0] req_pad;
  wire logic [rvm_pkg::GRP_N-1:0] grp_hit;
  wire logic [rvm_pkg::GRP_N*rvm_pkg::GRP_IDX_W-1:0] grp_low;
  logic [rvm_pkg::GRP_N-1:0] grp_grant;
  logic lower_seen;
  logic [rvm_pkg::ADDR_W-1:0] entry_ofs;
  logic [rvm_pkg::ADDR_W-1:0] entry_addr;
  logic take_ok;

  // ==========================================================================
  // Arbitration, first level: lowest request inside each group of eight
  // ==========================================================================
  // Sources are numbered in vector order, so the lowest index is the lowest
  // vector. Two levels, eight per group then seven groups, keep the priority path short, at the cost of
  // a few more gates than one flat scan over every source.
  assign req_pad = rvm_pkg::PAD_W'(src_req);

  for (genvar g = 0; g < rvm_pkg::GRP_N; g++) begin : g_grp
    logic hit;
    logic [rvm_pkg::GRP_IDX_W-1:0] low;
    always_comb begin
      hit = 1'b0;
      low = '0;
      for (int b = rvm_pkg::GRP_W - 1; b >= 0; b--) begin
        if (req_pad[g * rvm_pkg::GRP_W + b]) begin
          hit = 1'b1;
          low = rvm_pkg::GRP_IDX_W'(b);
        end
      end
    end
    assign grp_hit[g] = hit;
    assign grp_low[g * rvm_pkg::GRP_IDX_W +: rvm_pkg::GRP_IDX_W] = low;
  end

  // ==========================================================================
  // Arbitration, second level: lowest group with a request
  // ==========================================================================
  always_comb begin
    lower_seen = 1'b0;
    grp_grant = '0;
    for (int g = 0; g < rvm_pkg::GRP_N; g++) begin
      grp_grant[g] = grp_hit[g] && !lower_seen;
      lower_seen = lower_seen || grp_hit[g];
    end
  end

  always_comb begin
    win_src = rvm_pkg::SRC_NONE;
    for (int g = 0; g < rvm_pkg::GRP_N; g++) begin
      if (grp_grant[g]) begin
        win_src = rvm_pkg::SRC_W'(g * rvm_pkg::GRP_W)
          + rvm_pkg::SRC_W'(grp_low[g * rvm_pkg::GRP_IDX_W
          +: rvm_pkg::GRP_IDX_W]);
      end
    end
  end

  rvm_vec_map u_map (
    .src(win_src),
    .vec(win_vec),
    .used(win_used)
  );

  assign base = alt_table_select ? rvm_pkg::ALT_BASE
                                 : rvm_pkg::PRI_BASE;

  // ==========================================================================
  // Entry address
  // ==========================================================================
  // The table choice is frozen at the take edge; flipping the select bit
  // while a fetch is out does not move that fetch.
  assign entry_ofs = rvm_pkg::ADDR_W'({win_vec, 1'b0});
  assign entry_addr = base + entry_ofs;
  assign take_ok = take && win_used
    && (win_vec <= rvm_pkg::VEC_LAST);

  // ==========================================================================
  // Sequencing
  // ==========================================================================
  always_comb begin
    next_cur = cur;
    next_cur.hvalid = 1'b0;
    case (cur.state)
      rvm_pkg::ST_RESET: begin
        // Leaving reset goes straight to run; no table entry is read.
        next_cur.pc = rvm_pkg::RESET_ADDR;
        next_cur.state = rvm_pkg::ST_RUN;
      end
      rvm_pkg::ST_RUN: begin
        if (take_ok) begin
          next_cur.fetch.valid = 1'b1;
          next_cur.fetch.vec = win_vec;
          next_cur.fetch.addr = entry_addr;
          next_cur.state = rvm_pkg::ST_FETCH;
        end
      end
      rvm_pkg::ST_FETCH: begin
        if (entry_valid) begin
          next_cur.fetch.valid = 1'b0;
          next_cur.hvalid = 1'b1;
          next_cur.haddr = entry_data;
          next_cur.pc = entry_data;
          next_cur.state = rvm_pkg::ST_RUN;
        end
      end
      default: begin
        next_cur.state = rvm_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign reset_pc = cur.pc;
  assign fetch_req = cur.fetch.valid;
  assign fetch_addr = cur.fetch.addr;
  assign fetch_vec = cur.fetch.vec;
  assign handler_valid = cur.hvalid;
  assign handler_addr = cur.haddr;
  assign pending = win_used;

endmodule // rvm_top

// File: inc/rvm_pkg.sv
package rvm_pkg;

  // ==========================================================================
  // Widths and addresses
  // ==========================================================================
  localparam int VEC_W = 7;
  localparam int ADDR_W = 24;
  localparam int SRC_W = 6;
  localparam int NUM_SRC = 54;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 24'h000000;
  localparam logic [ADDR_W-1:0] PRI_BASE = 24'h000004;
  localparam logic [ADDR_W-1:0] ALT_BASE = 24'h000104;
  localparam logic [VEC_W-1:0] VEC_LAST = 7'h7E;
  localparam logic [VEC_W-1:0] VEC_NONE = 7'h00;
  localparam logic [SRC_W-1:0] SRC_NONE = 6'h3F;

  // ==========================================================================
  // Arbitration grouping
  // ==========================================================================
  localparam int GRP_W = 8;
  localparam int GRP_N = 7;
  localparam int GRP_IDX_W = 3;
  localparam int PAD_W = GRP_N * GRP_W;

  // ==========================================================================
  // Vector offset of each run of sources that sit on adjacent vectors
  // ==========================================================================
  localparam logic [VEC_W-1:0] OFS_TRAP = 7'h01;
  localparam logic [VEC_W-1:0] OFS_RUN_A = 7'h03;
  localparam logic [VEC_W-1:0] OFS_RUN_B = 7'h04;
  localparam logic [VEC_W-1:0] OFS_RUN_C = 7'h05;
  localparam logic [VEC_W-1:0] OFS_RUN_D = 7'h0D;
  localparam logic [VEC_W-1:0] OFS_RUN_E = 7'h19;
  localparam logic [VEC_W-1:0] OFS_RUN_F = 7'h1B;
  localparam logic [VEC_W-1:0] OFS_RUN_G = 7'h22;

  // ==========================================================================
  // Source numbering: index of each source in the request vector
  // ==========================================================================
  typedef enum logic [SRC_W-1:0] {
    SRC_OSC_FAIL, SRC_ADDR_ERR, SRC_STACK_ERR, SRC_MATH_ERR, SRC_DMA_ERR,
    SRC_EXT_IRQ_ZERO, SRC_IC1, SRC_OC1, SRC_T1, SRC_DMA0, SRC_IC2, SRC_OC2,
    SRC_T2, SRC_T3, SRC_SPI1_ERR, SRC_SPI1_DONE, SRC_U1_RX, SRC_U1_TX,
    SRC_ADC1, SRC_DMA1, SRC_I2C_SLV, SRC_I2C_MST, SRC_CMP, SRC_CHG_NOTE,
    SRC_EXT_IRQ_ONE, SRC_IC7, SRC_IC8, SRC_DMA2, SRC_OC3, SRC_OC4, SRC_T4,
    SRC_T5, SRC_EXT_IRQ_TWO, SRC_U2_RX, SRC_U2_TX, SRC_SPI2_ERR,
    SRC_SPI2_DONE, SRC_CAN_RX, SRC_CAN_EVT, SRC_DMA3, SRC_PAR_PORT,
    SRC_DMA4, SRC_CODEC_ERR, SRC_CODEC_DONE, SRC_DMA5, SRC_RTC,
    SRC_U1_ERR, SRC_U2_ERR, SRC_CRC, SRC_DMA6, SRC_DMA7, SRC_CAN_TX,
    SRC_DAC_RIGHT
  } rvm_src_e;
  localparam logic [SRC_W-1:0] SRC_DAC_LEFT = 6'h35;

  typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_FETCH} rvm_state_e;

  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vec;
    logic [ADDR_W-1:0] addr;
  } rvm_fetch_s;

endpackage

// File: hdl/rvm_vec_map.sv
`timescale 1ns/1ns
// ============================================================================
// Vector number of each source, and whether that source exists.
// ============================================================================
module rvm_vec_map (
  input wire logic [rvm_pkg::SRC_W-1:0] src,
  output logic [rvm_pkg::VEC_W-1:0] vec,
  output logic used
);
  always_comb begin
    used = 1'b1;
    if (src <= rvm_pkg::SRC_DMA_ERR) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_TRAP;
    end else if (src <= rvm_pkg::SRC_DMA1) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_A;
    end else if (src <= rvm_pkg::SRC_EXT_IRQ_ONE) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_B;
    end else if (src <= rvm_pkg::SRC_DMA3) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_C;
    end else if (src <= rvm_pkg::SRC_DMA4) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_D;
    end else if (src <= rvm_pkg::SRC_RTC) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_E;
    end else if (src <= rvm_pkg::SRC_CAN_TX) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_F;
    end else if (src <= rvm_pkg::SRC_DAC_LEFT) begin
      vec = rvm_pkg::VEC_W'(src) + rvm_pkg::OFS_RUN_G;
    end else begin
      vec = rvm_pkg::VEC_NONE;
      used = 1'b0;
    end
  end
endmodule // rvm_vec_map

// File: tb/rvm_core_mem.sv
`timescale 1ns/1ns
// ============================================================================
// Core memory model: returns table entries after a chosen latency.
// ============================================================================
module rvm_core_mem (
  input wire logic ref_clk,
  input wire logic fetch_req,
  input wire logic [rvm_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic [1:0] lat,
  output logic entry_valid,
  output logic [rvm_pkg::ADDR_W-1:0] entry_data
);
  logic [1:0] cnt;
  initial begin
    entry_valid = 1'b0;
    entry_data = 24'h000000;
    cnt = 2'h0;
  end
  // Idle data toggles every cycle so a stale entry is never mistaken.
  always @(posedge ref_clk) begin
    if (fetch_req && !entry_valid && cnt == lat) begin
      entry_valid <= 1'b1;
      entry_data <= ~fetch_addr;
      cnt <= 2'h0;
    end else begin
      entry_valid <= 1'b0;
      entry_data <= ~entry_data;
      cnt <= (fetch_req && !entry_valid) ? cnt + 2'h1 : 2'h0;
    end
  end
endmodule // rvm_core_mem

// File: tb/rvm_top_properties.sv
`timescale 1ns/1ns
// ============================================================================
// Port checker
// ============================================================================
module rvm_top_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [rvm_pkg::NUM_SRC-1:0] src_req,
  input wire logic alt_table_select,
  input wire logic take,
  input wire logic entry_valid,
  input wire logic [rvm_pkg::ADDR_W-1:0] entry_data,
  input wire logic [rvm_pkg::ADDR_W-1:0] reset_pc,
  input wire logic fetch_req,
  input wire logic [rvm_pkg::ADDR_W-1:0] fetch_addr,
  input wire logic [rvm_pkg::VEC_W-1:0] fetch_vec,
  input wire logic handler_valid,
  input wire logic [rvm_pkg::ADDR_W-1:0] handler_addr,
  input wire logic pending
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_take;
    take && (|src_req) && !fetch_req && $past(resetn);
  endsequence
  chk_take_fetch: assert property (s_take |=> fetch_req)
    else $error("no fetch after take");
  chk_entry_addr: assert property ($rose(fetch_req) |-> fetch_addr ==
    (($past(alt_table_select) ? rvm_pkg::ALT_BASE : rvm_pkg::PRI_BASE)
    + {fetch_vec, 1'b0}))
    else $error("entry address wrong");
  chk_fetch_hold: assert property (fetch_req && !entry_valid |=>
    fetch_req && $stable(fetch_addr)) else $error("fetch dropped");
  chk_entry_load: assert property (fetch_req && entry_valid |=>
    handler_valid && !fetch_req && handler_addr == $past(entry_data)
    && reset_pc == $past(entry_data)) else $error("entry not loaded");
  chk_valid_pulse: assert property (handler_valid |=> !handler_valid)
    else $error("handler valid too long");
  chk_reset_start: assert property ($rose(resetn) |->
    reset_pc == rvm_pkg::RESET_ADDR ##1 !fetch_req
    && reset_pc == rvm_pkg::RESET_ADDR)
    else $error("bad start after reset");
  chk_vec_used: assert property (fetch_req |-> !(fetch_vec inside
    {0, 6, 7, 23, 29, [45:52], [55:66], 71, 72, [79:85], [88:127]}))
    else $error("fetch of vector without source");
  chk_lowest_wins: assert property (s_take ##0 src_req[0] |=>
    fetch_vec == 7'h01) else $error("lowest vector lost");
  chk_pend_flag: assert property (pending == (|src_req))
    else $error("pending flag wrong");
endmodule // rvm_top_chk

// File: tb/tb_top.sv
`timescale 1ns/1ns
// ============================================================================
// Testbench
// ============================================================================
module tb_top;
  logic ref_clk, resetn, alt, take, ev, fr, hv, pend;
  logic [rvm_pkg::NUM_SRC-1:0] req;
  logic [rvm_pkg::ADDR_W-1:0] ed, rpc, fa, ha;
  logic [rvm_pkg::VEC_W-1:0] fv;
  logic [1:0] lat;
  int mismatches, n_checks;
  rvm_top rvm_top_i (.ref_clk(ref_clk), .resetn(resetn), .src_req(req),
    .alt_table_select(alt), .take(take), .entry_valid(ev), .entry_data(ed),
    .reset_pc(rpc), .fetch_req(fr), .fetch_addr(fa), .fetch_vec(fv),
    .handler_valid(hv), .handler_addr(ha), .pending(pend));
  rvm_core_mem rvm_core_mem_i (.ref_clk(ref_clk), .fetch_req(fr),
    .fetch_addr(fa), .lat(lat), .entry_valid(ev), .entry_data(ed));
  task check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Vector of source i: walk upwards, skipping vectors without a source.
  function automatic logic [6:0] vec_of(int i);
    logic [6:0] v;
    v = 7'h00;
    for (int n = 0; n <= i; n++) begin
      v++;
      while (v inside {6, 7, 23, 29, [45:52], [55:66], 71, 72, [79:85]}) v++;
    end
    return v;
  endfunction
  task t_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) begin
      @(posedge ref_clk);
      #1;
      check("reset_pc", rpc, 32'h0);
      check("fetch_req", fr, 32'h0);
      check("handler_valid", hv, 32'h0);
    end
  endtask
  task t_take(logic [rvm_pkg::NUM_SRC-1:0] m, logic [6:0] v, logic a,
    logic [1:0] l);
    logic [23:0] ex;
    logic [23:0] exh;
    ex = (a ? rvm_pkg::ALT_BASE : rvm_pkg::PRI_BASE) + {v, 1'b0};
    exh = ~ex;
    @(posedge ref_clk);
    req <= m;
    alt <= a;
    lat <= l;
    take <= 1'b1;
    #1;
    check("pending", pend, 32'h1);
    @(posedge ref_clk);
    take <= 1'b0;
    req <= '0;
    #1;
    check("fetch_vec", fv, v);
    check("fetch_addr", fa, ex);
    check("pending_idle", pend, 32'h0);
    for (int k = 0; k < 8 && hv !== 1'b1; k++) begin
      @(posedge ref_clk);
      #1;
    end
    check("handler_valid", hv, 32'h1);
    check("handler_addr", ha, exh);
    check("reset_pc", rpc, exh);
  endtask
  // Every source in turn, both tables, every memory latency.
  task t_sweep;
    for (int i = 0; i < rvm_pkg::NUM_SRC; i++) begin
      t_take(rvm_pkg::NUM_SRC'(1) << i, vec_of(i), i[0], i[1:0]);
    end
  endtask
  task t_priority;
    t_take({1'b1, 31'h0, 1'b1, 15'h0, 1'b1, 5'h0},
      7'h08, 1'b1, 2'h0);
    t_take(54'h3, 7'h01, 1'b0, 2'h3);
  endtask
  // A take with nothing pending must not start a fetch.
  task t_idle_take;
    @(posedge ref_clk);
    req <= '0;
    take <= 1'b1;
    @(posedge ref_clk);
    take <= 1'b0;
    #1;
    check("idle_fetch_req", fr, 32'h0);
    check("idle_pending", pend, 32'h0);
  endtask
  task t_restart;
    t_reset;
    t_take(54'h20, 7'h08, 1'b0, 2'h1);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
  initial begin
    {resetn, alt, take, req, lat} = '0;
    t_reset;
    t_sweep;
    t_priority;
    t_idle_take;
    t_restart;
    give_verdict;
  end
endmodule // tb_top
bind rvm_top rvm_top_chk rvm_top_chk_i (.ref_clk, .resetn, .src_req,
  .alt_table_select, .take, .entry_valid, .entry_data, .reset_pc,
  .fetch_req, .fetch_addr, .fetch_vec, .handler_valid, .handler_addr,
  .pending);
